// ==== logic/bsc_branch_skip_call.v ====
// Control-flow execution unit: compares, skips, branches, calls, returns
//
// How it works
// - Equal registers make compare-skip-equal skip; 1/2/3 cycles.
// - Compares set Z,N,V,C,H from difference, store nothing, one cycle.
// - Register bit reading 0 skips next instruction; 1/2/3 cycles.
// - Register bit reading 1 skips next instruction; 1/2/3 cycles.
// - I/O bit reading 0 skips next instruction; 1/2/3 cycles.
// - I/O bit reading 1 skips next instruction; 1/2/3 cycles.
// - Selected flag set loads PC+k+1, else sequential.
// - Selected flag clear loads PC+k+1; one cycle untaken, two taken.
// - Same-or-higher branches on carry 0, lower on carry 1.
// - Signed greater-or-equal branches when N xor V is 0.
// - Half-carry branches test H clear or set, 1 or 2 cycles.
// - Transfer-flag branch taken when T is 1, 1 or 2 cycles.
// - Indirect call loads Z in 3 cycles, direct call k in 4.
`timescale 1ns/10ps
`default_nettype none
`include "bsc_defs.vh"

module bsc_branch_skip_call (
    input  wire                     ref_clk,
    input  wire                     nrst,
    // Instruction issue
    input  wire                     opValid,
    input  wire [`BSC_OP_W-1:0]     opCode,
    input  wire [7:0]               opdA,
    input  wire [7:0]               opdB,
    input  wire [2:0]               bitSel,
    input  wire [7:0]               ioByte,
    input  wire [`BSC_OFS_W-1:0]    branchOfs,
    input  wire [`BSC_PC_W-1:0]     callTarget,
    input  wire [`BSC_PC_W-1:0]     zPointer,
    input  wire [`BSC_PC_W-1:0]     pcIn,
    input  wire [7:0]               statusIn,
    input  wire                     nextTwoWord,
    input  wire [`BSC_PC_W-1:0]     stackData,
    // Results toward the core
    output reg                      busy_q,
    output reg                      done_q,
    output reg                      pcLoad_q,
    output reg  [`BSC_PC_W-1:0]     pcNext_q,
    output reg                      flagWe_q,
    output reg  [7:0]               flagMask_q,
    output reg  [7:0]               flagValue_q,
    output reg                      pushReq_q,
    output reg  [`BSC_PC_W-1:0]     pushData_q,
    output reg                      popReq_q
);

    // ========================================================
    // Compare datapath
    wire [7:0] cmpDiff;
    wire       cmpZ;
    wire       cmpN;
    wire       cmpV;
    wire       cmpC;
    wire       cmpH;
    wire       useBorrow;

    // Only compare-with-borrow folds the old carry in
    assign useBorrow = (opCode == `BSC_OP_COMPARE_WITH_BORROW) &
                       statusIn[`BSC_FLAG_C];

    bsc_cmp_alu i_bsc_cmp_alu (
        .minuend    (opdA),
        .subtrahend (opdB),
        .borrowIn   (useBorrow),
        .diff       (cmpDiff),
        .flagZ      (cmpZ),
        .flagN      (cmpN),
        .flagV      (cmpV),
        .flagC      (cmpC),
        .flagH      (cmpH)
    );

    // ========================================================
    // Address candidates
    wire [`BSC_PC_W-1:0] pcPlusOne;
    wire [`BSC_PC_W-1:0] skipTarget;
    wire [`BSC_CYC_W-1:0] skipCycles;
    wire [`BSC_PC_W-1:0] ofsExt;
    wire [`BSC_PC_W-1:0] branchTarget;
    wire                 signedLess;

    assign pcPlusOne  = pcIn + `BSC_PC_ONE_WORD;
    // Skipping a two-word instruction costs one extra word and cycle
    assign skipTarget = nextTwoWord ? (pcIn + `BSC_PC_SKIP_LONG)
                                    : (pcIn + `BSC_PC_SKIP_SHORT);
    assign skipCycles = nextTwoWord ? `BSC_CYC_THREE : `BSC_CYC_TWO;
    // Branch offset is a signed word count
    assign ofsExt     = {{`BSC_OFS_EXT{branchOfs[`BSC_OFS_SIGN]}}, branchOfs};
    assign branchTarget = pcIn + ofsExt + `BSC_PC_ONE_WORD;
    assign signedLess = statusIn[`BSC_FLAG_N] ^ statusIn[`BSC_FLAG_V];

    // ========================================================
    // Decode of the issued operation
    reg                   opKnown;
    reg                   condTrue;
    reg                   isSkip;
    reg                   isBranch;
    reg                   isCall;
    reg                   isRet;
    reg  [`BSC_CYC_W-1:0] cycles;
    reg  [`BSC_PC_W-1:0]  target;
    reg  [`BSC_PC_W-1:0]  retAddr;
    reg                   flagWeNew;
    reg  [7:0]            flagMaskNew;
    reg  [7:0]            flagValueNew;

    always @* begin
        opKnown      = 1'b1;
        condTrue     = 1'b0;
        isSkip       = 1'b0;
        isBranch     = 1'b0;
        isCall       = 1'b0;
        isRet        = 1'b0;
        cycles       = `BSC_CYC_ONE;
        target       = pcPlusOne;
        retAddr      = pcPlusOne;
        flagWeNew    = 1'b0;
        flagMaskNew  = `BSC_FLAGS_NONE;
        flagValueNew = `BSC_FLAGS_NONE;
        // Unlisted codes fall to default and never issue
        case (opCode)
            `BSC_OP_COMPARE_REGS,
            `BSC_OP_COMPARE_WITH_BORROW,
            `BSC_OP_COMPARE_IMMEDIATE: begin
                flagWeNew                 = 1'b1;
                flagMaskNew               = `BSC_CMP_FLAG_MASK;
                flagValueNew[`BSC_FLAG_Z] = cmpZ;
                flagValueNew[`BSC_FLAG_N] = cmpN;
                flagValueNew[`BSC_FLAG_V] = cmpV;
                flagValueNew[`BSC_FLAG_C] = cmpC;
                flagValueNew[`BSC_FLAG_H] = cmpH;
            end
            `BSC_OP_COMPARE_SKIP_EQUAL: begin
                isSkip = 1'b1;
                condTrue = (opdA == opdB);
            end
            `BSC_OP_SKIP_REG_BIT_CLEAR: begin
                isSkip = 1'b1;
                condTrue = ~opdA[bitSel];
            end
            `BSC_OP_SKIP_REG_BIT_SET: begin
                isSkip = 1'b1;
                condTrue = opdA[bitSel];
            end
            `BSC_OP_SKIP_IO_BIT_CLEAR: begin
                isSkip = 1'b1;
                condTrue = ~ioByte[bitSel];
            end
            `BSC_OP_SKIP_IO_BIT_SET: begin
                isSkip = 1'b1;
                condTrue = ioByte[bitSel];
            end
            `BSC_OP_BRANCH_FLAG_SET: begin
                isBranch = 1'b1;
                condTrue = statusIn[bitSel];
            end
            `BSC_OP_BRANCH_FLAG_CLEAR: begin
                isBranch = 1'b1;
                condTrue = ~statusIn[bitSel];
            end
            `BSC_OP_BRANCH_SIGNED_GE: begin
                isBranch = 1'b1;
                condTrue = ~signedLess;
            end
            `BSC_OP_BRANCH_SIGNED_LESS: begin
                isBranch = 1'b1;
                condTrue = signedLess;
            end
            `BSC_OP_INDIRECT_SUBROUTINE_JUMP: begin
                isCall = 1'b1;
                target  = zPointer;
                retAddr = pcPlusOne;
                cycles  = `BSC_CYC_THREE;
            end
            `BSC_OP_DIRECT_CALL: begin
                isCall = 1'b1;
                target  = callTarget;
                retAddr = pcIn + `BSC_CALL_RET_OFS;
                cycles  = `BSC_CYC_FOUR;
            end
            `BSC_OP_SUBROUTINE_RETURN,
            `BSC_OP_INTERRUPT_RETURN: begin
                isRet = 1'b1;
                cycles = `BSC_CYC_FOUR;
            end
            default: begin
                opKnown = 1'b0;
            end
        endcase
        // Taken skips and branches override the defaults
        if (isSkip && condTrue) begin
            target = skipTarget;
            cycles = skipCycles;
        end
        if (isBranch && condTrue) begin
            target = branchTarget;
            cycles = `BSC_CYC_TWO;
        end
    end

    // ========================================================
    // Multi-cycle sequencing
    // Cycles left before the completion edge
    reg  [`BSC_CYC_W-1:0] cnt_q;
    reg  [`BSC_PC_W-1:0]  pcHold_q;
    reg                   retHold_q;
    reg                   intRetHold_q;
    wire                  issue;
    wire                  lastCycle;

    // Requests while busy are not taken; the core must hold them
    assign issue     = opValid & opKnown & ~busy_q;
    assign lastCycle = busy_q & (cnt_q == `BSC_CNT_ZERO);

    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            busy_q       <= 1'b0;
            done_q       <= 1'b0;
            pcLoad_q     <= 1'b0;
            pcNext_q     <= `BSC_PC_ZERO;
            flagWe_q     <= 1'b0;
            flagMask_q   <= `BSC_FLAGS_NONE;
            flagValue_q  <= `BSC_FLAGS_NONE;
            pushReq_q    <= 1'b0;
            pushData_q   <= `BSC_PC_ZERO;
            popReq_q     <= 1'b0;
            cnt_q        <= `BSC_CNT_ZERO;
            pcHold_q     <= `BSC_PC_ZERO;
            retHold_q    <= 1'b0;
            intRetHold_q <= 1'b0;
        end else begin
            // Pulses default low so each lasts one cycle
            done_q    <= 1'b0;
            pcLoad_q  <= 1'b0;
            flagWe_q  <= 1'b0;
            pushReq_q <= 1'b0;
            popReq_q  <= 1'b0;
            if (issue) begin
                if (cycles == `BSC_CYC_ONE) begin
                    done_q      <= 1'b1;
                    pcLoad_q    <= 1'b1;
                    pcNext_q    <= target;
                    flagWe_q    <= flagWeNew;
                    flagMask_q  <= flagMaskNew;
                    flagValue_q <= flagValueNew;
                end else begin
                    busy_q       <= 1'b1;
                    cnt_q        <= cycles - `BSC_CYC_TWO;
                    pcHold_q     <= target;
                    retHold_q    <= isRet;
                    intRetHold_q <= (opCode == `BSC_OP_INTERRUPT_RETURN);
                    // push return address, no flags touched
                    pushReq_q    <= isCall;
                    pushData_q   <= retAddr;
                    popReq_q     <= isRet;
                end
            end else if (lastCycle) begin
                // Stack word read late so the pop has settled
                busy_q   <= 1'b0;
                done_q   <= 1'b1;
                pcLoad_q <= 1'b1;
                pcNext_q <= retHold_q ? stackData : pcHold_q;
                if (intRetHold_q) begin
                    flagWe_q    <= 1'b1;
                    flagMask_q  <= `BSC_INT_FLAG_MASK;
                    flagValue_q <= `BSC_INT_FLAG_MASK;
                end
            end else if (busy_q) begin
                cnt_q <= cnt_q - `BSC_CNT_STEP;
            end
        end
    end

endmodule // bsc_branch_skip_call

`default_nettype wire

// ==== logic/bsc_cmp_alu.v ====
// Flag-producing subtractor for the compare instructions
`timescale 1ns/10ps
`default_nettype none

module bsc_cmp_alu (
    input  wire [7:0] minuend,
    input  wire [7:0] subtrahend,
    input  wire       borrowIn,
    output wire [7:0] diff,
    output wire       flagZ,
    output wire       flagN,
    output wire       flagV,
    output wire       flagC,
    output wire       flagH
);

    // ========================================================
    // Ripple borrow chain
    wire [8:0] borrow;

    assign borrow[0] = borrowIn;

    genvar i;
    generate
        for (i = 0; i < 8; i = i + 1) begin : gBit
            assign diff[i]     = minuend[i] ^ subtrahend[i] ^ borrow[i];
            assign borrow[i+1] = (~minuend[i] & subtrahend[i]) |
                                 (~(minuend[i] ^ subtrahend[i]) & borrow[i]);
        end
    endgenerate

    // ========================================================
    // Flag derivation
    assign flagZ = (diff == 8'h00);
    assign flagN = diff[7];
    assign flagC = borrow[8];
    // Borrow out of the low nibble
    assign flagH = borrow[4];
    assign flagV = (minuend[7] & ~subtrahend[7] & ~diff[7]) |
                   (~minuend[7] & subtrahend[7] & diff[7]);

endmodule // bsc_cmp_alu

`default_nettype wire

// ==== logic/bsc_defs.vh ====
// Constants shared by the branch, skip and call control unit
`ifndef BSC_DEFS_VH
`define BSC_DEFS_VH

// ============================================================
// Operation codes presented on opCode
`define BSC_OP_W                        5
`define BSC_OP_NONE                     5'h00
`define BSC_OP_COMPARE_REGS             5'h01
`define BSC_OP_COMPARE_WITH_BORROW      5'h02
`define BSC_OP_COMPARE_IMMEDIATE        5'h03
`define BSC_OP_COMPARE_SKIP_EQUAL       5'h04
`define BSC_OP_SKIP_REG_BIT_CLEAR       5'h05
`define BSC_OP_SKIP_REG_BIT_SET         5'h06
`define BSC_OP_SKIP_IO_BIT_CLEAR        5'h07
`define BSC_OP_SKIP_IO_BIT_SET          5'h08
`define BSC_OP_BRANCH_FLAG_SET          5'h09
`define BSC_OP_BRANCH_FLAG_CLEAR        5'h0A
`define BSC_OP_BRANCH_SIGNED_GE         5'h0B
`define BSC_OP_BRANCH_SIGNED_LESS       5'h0C
`define BSC_OP_INDIRECT_SUBROUTINE_JUMP 5'h0D
`define BSC_OP_DIRECT_CALL              5'h0E
`define BSC_OP_SUBROUTINE_RETURN        5'h0F
`define BSC_OP_INTERRUPT_RETURN         5'h10

// ============================================================
// Bit positions in status_flags_register
`define BSC_FLAG_C                      0
`define BSC_FLAG_Z                      1
`define BSC_FLAG_N                      2
`define BSC_FLAG_V                      3
`define BSC_FLAG_S                      4
`define BSC_FLAG_H                      5
`define BSC_FLAG_T                      6
`define BSC_FLAG_I                      7
// Flags written by the compare group: Z, N, V, C, H
`define BSC_CMP_FLAG_MASK               8'h2F
`define BSC_INT_FLAG_MASK               8'h80
`define BSC_FLAGS_NONE                  8'h00

// ============================================================
// Cycle counts per instruction outcome
`define BSC_CYC_W                       3
`define BSC_CYC_ONE                     3'h1
`define BSC_CYC_TWO                     3'h2
`define BSC_CYC_THREE                   3'h3
`define BSC_CYC_FOUR                    3'h4
`define BSC_CNT_ZERO                    3'h0
`define BSC_CNT_STEP                    3'h1

// ============================================================
// Program counter arithmetic
`define BSC_PC_W                        16
`define BSC_PC_ZERO                     16'h0000
`define BSC_PC_ONE_WORD                 16'h0001
`define BSC_PC_SKIP_SHORT               16'h0002
`define BSC_PC_SKIP_LONG                16'h0003
`define BSC_CALL_RET_OFS                16'h0002
`define BSC_OFS_W                       7
`define BSC_OFS_SIGN                    6
`define BSC_OFS_EXT                     9

`endif

// ==== test/bsc_branch_skip_call_checker.sv ====
// Port-level assertions for the control-flow unit
`timescale 1ns/10ps
`default_nettype none
`include "bsc_defs.vh"

module bsc_checker (
    input wire logic        ref_clk,
    input wire logic        nrst,
    input wire logic        opValid,
    input wire logic [4:0]  opCode,
    input wire logic [7:0]  opdA,
    input wire logic [7:0]  opdB,
    input wire logic [2:0]  bitSel,
    input wire logic [7:0]  ioByte,
    input wire logic [6:0]  branchOfs,
    input wire logic [15:0] callTarget,
    input wire logic [15:0] pcIn,
    input wire logic [7:0]  statusIn,
    input wire logic        nextTwoWord,
    input wire logic [15:0] stackData,
    input wire logic        busy_q,
    input wire logic        done_q,
    input wire logic        pcLoad_q,
    input wire logic [15:0] pcNext_q,
    input wire logic        flagWe_q,
    input wire logic [7:0]  flagMask_q,
    input wire logic [7:0]  flagValue_q,
    input wire logic        pushReq_q,
    input wire logic [15:0] pushData_q,
    input wire logic        popReq_q
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    // Requests seen while busy are dropped by the unit
    wire logic        take = opValid && !busy_q;
    wire logic [15:0] ofsExt = {{9{branchOfs[6]}}, branchOfs};

    // ========
    // Steps
    sequence s_take(logic [4:0] op, logic cond);
        take && opCode == op && cond;
    endsequence
    sequence s_stack_wait;
        busy_q [*2] ##1 done_q;
    endsequence

    // ========
    // Checks
    cmp_one_cycle_a: assert property (
        take && opCode >= `BSC_OP_COMPARE_REGS
        && opCode <= `BSC_OP_COMPARE_IMMEDIATE |=> done_q && flagWe_q
        && flagMask_q == `BSC_CMP_FLAG_MASK
        && pcNext_q == $past(pcIn) + 16'h0001) else $error("compare");
    skip_bit_set_a: assert property (
        s_take(`BSC_OP_SKIP_REG_BIT_SET, opdA[bitSel] && !nextTwoWord)
        |=> busy_q ##1 done_q && pcNext_q == $past(pcIn, 2) + 16'h0002)
        else $error("skip on set bit");
    io_clear_keep_a: assert property (
        s_take(`BSC_OP_SKIP_IO_BIT_CLEAR, ioByte[bitSel]) |=> done_q
        && !busy_q && pcNext_q == $past(pcIn) + 16'h0001)
        else $error("io skip not sequential");
    branch_taken_a: assert property (
        s_take(`BSC_OP_BRANCH_FLAG_SET, statusIn[bitSel]) |=> busy_q ##1
        pcLoad_q && pcNext_q == $past(pcIn, 2) + $past(ofsExt, 2) + 16'h0001)
        else $error("taken branch");
    branch_idle_a: assert property (
        s_take(`BSC_OP_BRANCH_FLAG_CLEAR, statusIn[bitSel]) |=> done_q
        && pcNext_q == $past(pcIn) + 16'h0001) else $error("untaken branch");
    signed_less_a: assert property (
        s_take(`BSC_OP_BRANCH_SIGNED_LESS, statusIn[2] ^ statusIn[3])
        |=> busy_q ##1 done_q) else $error("signed less");
    direct_call_a: assert property (
        s_take(`BSC_OP_DIRECT_CALL, 1'b1) |=> pushReq_q && busy_q
        && pushData_q == $past(pcIn) + 16'h0002 ##1 s_stack_wait
        ##0 pcNext_q == $past(callTarget, 4)) else $error("direct call");
    sub_return_a: assert property (
        s_take(`BSC_OP_SUBROUTINE_RETURN, 1'b1) |=> popReq_q && busy_q
        ##1 s_stack_wait ##0 !flagWe_q && pcNext_q == $past(stackData))
        else $error("return");
    int_return_a: assert property (
        s_take(`BSC_OP_INTERRUPT_RETURN, 1'b1) |=> popReq_q ##1
        s_stack_wait ##0 flagWe_q && flagMask_q == `BSC_INT_FLAG_MASK
        && flagValue_q[7] && pcNext_q == $past(stackData))
        else $error("interrupt return");
    skip_equal_long_a: assert property (
        s_take(`BSC_OP_COMPARE_SKIP_EQUAL, opdA == opdB && nextTwoWord)
        |=> busy_q [*2] ##1 done_q && pcNext_q == $past(pcIn, 3) + 16'h0003)
        else $error("skip over two words");
    done_load_a: assert property (
        done_q |-> pcLoad_q && !busy_q) else $error("done without load");
endmodule // bsc_checker

bind bsc_branch_skip_call bsc_checker i_bsc_checker (
    .ref_clk     (ref_clk),
    .nrst        (nrst),
    .opValid     (opValid),
    .opCode      (opCode),
    .opdA        (opdA),
    .opdB        (opdB),
    .bitSel      (bitSel),
    .ioByte      (ioByte),
    .branchOfs   (branchOfs),
    .callTarget  (callTarget),
    .pcIn        (pcIn),
    .statusIn    (statusIn),
    .nextTwoWord (nextTwoWord),
    .stackData   (stackData),
    .busy_q      (busy_q),
    .done_q      (done_q),
    .pcLoad_q    (pcLoad_q),
    .pcNext_q    (pcNext_q),
    .flagWe_q    (flagWe_q),
    .flagMask_q  (flagMask_q),
    .flagValue_q (flagValue_q),
    .pushReq_q   (pushReq_q),
    .pushData_q  (pushData_q),
    .popReq_q    (popReq_q)
);

`default_nettype wire

// ==== test/bsc_tb.sv ====
// Random and directed bench for the control-flow unit
`timescale 1ns/10ps
`default_nettype none
`include "bsc_defs.vh"

module tb;
    logic        ref_clk, nrst, opValid, nextTwoWord;
    logic [4:0]  opCode;
    logic [7:0]  opdA, opdB, ioByte, statusIn;
    logic [2:0]  bitSel;
    logic [6:0]  branchOfs;
    logic [15:0] callTarget, zPointer, pcIn, stackData;
    wire logic   busy_q, done_q, pcLoad_q, flagWe_q, pushReq_q, popReq_q;
    wire logic [15:0] pcNext_q, pushData_q;
    wire logic [7:0]  flagMask_q, flagValue_q;
    int          failures = 0;
    int          tests_run = 0;
    int          cycles = 0;
    logic [31:0] seed;

    bsc_branch_skip_call i_bsc_branch_skip_call (
        .ref_clk     (ref_clk),
        .nrst        (nrst),
        .opValid     (opValid),
        .opCode      (opCode),
        .opdA        (opdA),
        .opdB        (opdB),
        .bitSel      (bitSel),
        .ioByte      (ioByte),
        .branchOfs   (branchOfs),
        .callTarget  (callTarget),
        .zPointer    (zPointer),
        .pcIn        (pcIn),
        .statusIn    (statusIn),
        .nextTwoWord (nextTwoWord),
        .stackData   (stackData),
        .busy_q      (busy_q),
        .done_q      (done_q),
        .pcLoad_q    (pcLoad_q),
        .pcNext_q    (pcNext_q),
        .flagWe_q    (flagWe_q),
        .flagMask_q  (flagMask_q),
        .flagValue_q (flagValue_q),
        .pushReq_q   (pushReq_q),
        .pushData_q  (pushData_q),
        .popReq_q    (popReq_q)
    );

    // ========
    // Clock and hang guard
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        // Far above the fewer than two thousand cycles the run needs
        if (cycles == 20000) begin
            failures++;
            test_done();
        end
    end

    // ========
    // Helpers
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // {cycles, flag write, mask, value, next pc}
    function automatic logic [35:0] predict();
        logic [8:0]  r;
        logic [7:0]  f, m;
        logic        hit, br, we;
        logic [2:0]  n;
        logic [15:0] pc;
        r = {1'h0, opdA} - {1'h0, opdB}
            - 9'((opCode == `BSC_OP_COMPARE_WITH_BORROW) & statusIn[0]);
        f = {2'h0, (~opdA[3] & opdB[3]) | (opdB[3] & r[3]) | (r[3] & ~opdA[3]),
             1'h0, (opdA[7] ^ opdB[7]) & (opdA[7] ^ r[7]), r[7],
             r[7:0] == 8'h00, r[8]};
        {hit, br, we, m} = 11'h000;
        n = 3'h1;
        pc = pcIn + 16'h0001;
        case (opCode)
        `BSC_OP_COMPARE_REGS, `BSC_OP_COMPARE_WITH_BORROW,
        `BSC_OP_COMPARE_IMMEDIATE:  {we, m} = {1'h1, 8'h2f};
        `BSC_OP_COMPARE_SKIP_EQUAL: hit = opdA == opdB;
        `BSC_OP_SKIP_REG_BIT_CLEAR: hit = !opdA[bitSel];
        `BSC_OP_SKIP_REG_BIT_SET:   hit = opdA[bitSel];
        `BSC_OP_SKIP_IO_BIT_CLEAR:  hit = !ioByte[bitSel];
        `BSC_OP_SKIP_IO_BIT_SET:    hit = ioByte[bitSel];
        `BSC_OP_BRANCH_FLAG_SET:    {br, hit} = {1'h1, statusIn[bitSel]};
        `BSC_OP_BRANCH_FLAG_CLEAR:  {br, hit} = {1'h1, !statusIn[bitSel]};
        `BSC_OP_BRANCH_SIGNED_GE:
            {br, hit} = {1'h1, statusIn[2] ~^ statusIn[3]};
        `BSC_OP_BRANCH_SIGNED_LESS:
            {br, hit} = {1'h1, statusIn[2] ^ statusIn[3]};
        `BSC_OP_INDIRECT_SUBROUTINE_JUMP: {n, pc} = {3'h3, zPointer};
        `BSC_OP_DIRECT_CALL:        {n, pc} = {3'h4, callTarget};
        `BSC_OP_SUBROUTINE_RETURN:  {n, pc} = {3'h4, stackData};
        `BSC_OP_INTERRUPT_RETURN:   {n, pc, we, m} = {3'h4, stackData, 9'h180};
        default: ;
        endcase
        if (hit && br)
            {n, pc} = {3'h2, pcIn + {{9{branchOfs[6]}}, branchOfs} + 16'h0001};
        else if (hit)
            {n, pc} = {3'h2 + 3'(nextTwoWord),
                       pcIn + 16'h0002 + 16'(nextTwoWord)};
        return {n, we, m, (f | 8'h80) & m, pc};
    endfunction

    task automatic chk(input string name, input logic [15:0] expv, got);
        tests_run++;
        if (got !== expv) begin
            failures++;
            $display("Error %s expected %h seen %h", name, expv, got);
        end
    endtask

    task automatic shake();
        {opdA, opdB, ioByte, statusIn} = rnd();
        {callTarget, zPointer} = rnd();
        {pcIn, stackData} = rnd();
        {branchOfs, bitSel, nextTwoWord} = 11'(rnd());
    endtask

    // Noise keeps a request up while busy; it must be dropped
    task automatic run_op(input logic [4:0] op, input logic noise);
        logic [35:0] e;
        logic [1:0]  stk;
        logic [15:0] pushed;
        int          n;
        opCode = op;
        opValid = 1'b1;
        e = predict();
        stk[1] = op == `BSC_OP_DIRECT_CALL
                 || op == `BSC_OP_INDIRECT_SUBROUTINE_JUMP;
        stk[0] = op == `BSC_OP_SUBROUTINE_RETURN
                 || op == `BSC_OP_INTERRUPT_RETURN;
        pushed = pcIn + ((op == `BSC_OP_DIRECT_CALL) ? 16'h0002 : 16'h0001);
        @(posedge ref_clk);
        #1;
        n = 1;
        chk("stackReq", 16'(stk), 16'({pushReq_q, popReq_q}));
        if (stk[1]) chk("pushData", pushed, pushData_q);
        while (done_q !== 1'b1 && n < 8) begin
            opValid = noise;
            opCode = `BSC_OP_COMPARE_REGS;
            @(posedge ref_clk);
            #1;
            n++;
        end
        chk("cycles", 16'(e[35:33]), 16'(n));
        chk("pcLoad", 16'h0001, 16'(pcLoad_q));
        chk("pcNext", e[15:0], pcNext_q);
        chk("flagWe", 16'(e[32]), 16'(flagWe_q));
        if (e[32]) chk("mask", 16'(e[31:24]), 16'(flagMask_q));
        if (e[32])
            chk("flags", 16'(e[23:16]), 16'(flagValue_q & e[31:24]));
    endtask

    task automatic quiet(input int n);
        repeat (n) begin
            @(posedge ref_clk);
            #1;
            chk("doneQuiet", 16'h0000, 16'(done_q));
        end
    endtask

    task automatic test_done();
        if (failures == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // ========
    // Sequence
    initial begin
        seed = 32'hff03_6e2c;
        {nrst, opValid, opCode, opdA, opdB, ioByte, statusIn} = '0;
        {bitSel, branchOfs, nextTwoWord} = '0;
        {callTarget, zPointer, pcIn, stackData} = '0;
        repeat (20) @(posedge ref_clk);
        #1;
        nrst = 1'b1;
        @(posedge ref_clk);
        #1;
        chk("resetOut", 16'h0000, 16'({done_q, busy_q, flagWe_q}));
        // Every code, flags and offsets at both extremes
        for (int i = 1; i <= 16; i++) begin
            for (int j = 0; j < 4; j++) begin
                shake();
                pcIn = {16{j[0]}};
                ioByte = {8{j[0]}};
                statusIn = ioByte ^ {4'h0, j[1], 3'h0};
                opdB = j[1] ? opdA : ~opdA;
                nextTwoWord = j[1];
                branchOfs = j[1] ? 7'h40 : 7'h3f;
                run_op(5'(i), j[1]);
            end
        end
        for (int i = 0; i < 400; i++) begin
            shake();
            run_op(5'(1 + rnd() % 16), rnd() >> 31);
        end
        opValid = 1'b1;
        opCode = 5'h11;
        quiet(3);
        opCode = 5'h00;
        quiet(3);
        // Reset in the middle of a call drops it
        opCode = `BSC_OP_DIRECT_CALL;
        @(posedge ref_clk);
        #1;
        opValid = 1'b0;
        @(posedge ref_clk);
        #1;
        nrst = 1'b0;
        #1;
        chk("busyInReset", 16'h0000, 16'({busy_q, pushReq_q}));
        @(posedge ref_clk);
        #1;
        nrst = 1'b1;
        quiet(5);
        test_done();
    end
endmodule // tb

`default_nettype wire
